/* aes_pkg.sv */
`default_nettype none
package aes_pkg;

  // Key size codes held in the cipher control register.
  localparam logic [1:0] KS_128 = 2'h0;
  localparam logic [1:0] KS_192 = 2'h1;
  localparam logic [1:0] KS_256 = 2'h2;

  // Bit positions of the cipher control register.
  localparam int CCR_START     = 0;
  localparam int CCR_DECRYPT   = 1;
  localparam int CCR_KS_LO     = 2;
  localparam int CCR_KS_HI     = 3;
  localparam int CCR_JITTER    = 4;
  localparam int CCR_IRQ_EN    = 5;
  localparam int CCR_KEYGEN    = 6;
  localparam int CCR_DONE      = 7;
  localparam int CCR_W         = 8;
  localparam logic [7:0] CCR_RESET = 8'h00;

  // Cryptographic memory: 128-bit words, one-cycle read latency.
  localparam int MEM_AW = 4;
  localparam int MEM_DW = 128;
  localparam logic [3:0] MEM_KEY_LO   = 4'h0;
  localparam logic [3:0] MEM_KEY_HI   = 4'h1;
  localparam logic [3:0] MEM_DATA_IN  = 4'h2;
  localparam logic [3:0] MEM_DATA_OUT = 4'h3;

  // Cycles from start to completion without jitter.
  localparam logic [6:0] CYC_128 = 7'h37;
  localparam logic [6:0] CYC_192 = 7'h46;
  localparam logic [6:0] CYC_256 = 7'h4B;
  localparam logic [4:0] JIT_MAX_PRE   = 5'h0F;
  localparam logic [6:0] JIT_MAX_TOTAL = 7'h1E;
  localparam int KS_WORDS_MAX = 60;
  localparam logic [2:0] RNG_WORDS_LAST = 3'h7;

  localparam logic [31:0] ENC_MIX = 32'h0203_0101;
  localparam logic [31:0] DEC_MIX = 32'h0E0B_0D09;

  typedef enum logic [3:0] {
    ST_IDLE, ST_PRE, ST_RD_KEY_LO, ST_RD_KEY_HI, ST_RD_DATA, ST_CAP_DATA, ST_EXPAND,
    ST_ROUND, ST_WRITE, ST_WAIT, ST_GEN, ST_GEN_WR_LO, ST_GEN_WR_HI
  } state_t;

  function automatic logic [7:0] xtime(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1B : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    logic [7:0] x;
    r = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) r = r ^ x;
      x = xtime(x);
    end
    return r;
  endfunction

  // Multiplicative inverse as x^254; zero maps to zero.
  function automatic logic [7:0] gf_inv(input logic [7:0] x);
    logic [7:0] r;
    logic [7:0] p;
    r = 8'h01;
    p = x;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] b;
    b = gf_inv(x);
    return b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]} ^ 8'h63;
  endfunction

  function automatic logic [7:0] inv_sbox(input logic [7:0] s);
    return gf_inv({s[6:0], s[7]} ^ {s[4:0], s[7:5]} ^ {s[1:0], s[7:2]} ^ 8'h05);
  endfunction

  function automatic logic [31:0] sub_word(input logic [31:0] w);
    return {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  endfunction

  function automatic logic [7:0] rcon(input logic [3:0] n);
    logic [7:0] r;
    r = 8'h01;
    for (int i = 1; i < 10; i++) begin
      if (4'(i) < n) r = xtime(r);
    end
    return r;
  endfunction

  function automatic logic [3:0] key_nk(input logic [1:0] ks);
    case (ks)
      KS_192:  return 4'h6;
      KS_256:  return 4'h8;
      default: return 4'h4;
    endcase
  endfunction

  function automatic logic [6:0] base_cycles(input logic [1:0] ks);
    case (ks)
      KS_192:  return CYC_192;
      KS_256:  return CYC_256;
      default: return CYC_128;
    endcase
  endfunction

endpackage
`default_nettype wire

/* aes_round.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_round (
  input  wire logic [127:0] state_in,
  input  wire logic [127:0] rkey,
  input  wire logic         decrypt,
  input  wire logic         last,
  output logic      [127:0] state_out
);
  import aes_pkg::*;

  // Encryption: sub, shift, mix, add key. Decryption: inverse shift, inverse sub, add key, inverse mix.
  always_comb begin
    logic [7:0]  a [16];
    logic [7:0]  b [16];
    logic [7:0]  acc;
    logic [31:0] mix;
    for (int k = 0; k < 16; k++) begin
      a[k] = state_in[127 - 8*k -: 8];
      b[k] = 8'h00;
    end
    acc = 8'h00;
    mix = decrypt ? DEC_MIX : ENC_MIX;
    state_out = 128'h0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        if (decrypt) begin
          b[4*c + r] = inv_sbox(a[4*((c + 4 - r) % 4) + r]) ^ rkey[127 - 8*(4*c + r) -: 8];
        end else begin
          b[4*c + r] = sbox(a[4*((c + r) % 4) + r]);
        end
      end
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        acc = 8'h00;
        for (int k = 0; k < 4; k++) begin
          acc = acc ^ gmul(b[4*c + (r + k) % 4], mix[31 - 8*k -: 8]);
        end
        if (last) acc = b[4*c + r];
        if (!decrypt) acc = acc ^ rkey[127 - 8*(4*c + r) -: 8];
        state_out[127 - 8*(4*c + r) -: 8] = acc;
      end
    end
  end

endmodule // aes_round
`default_nettype wire

/* aes_key_sched.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_key_sched (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic         step,
  input  wire logic [3:0]   nk,
  input  wire logic [255:0] key,
  input  wire logic [3:0]   rk_idx,
  output logic      [127:0] rkey,
  output logic              ready
);
  import aes_pkg::*;

  logic [31:0] w [KS_WORDS_MAX];
  logic [31:0] nw [4];
  logic [5:0]  cnt;
  logic [5:0]  nk6;
  logic [5:0]  total;

  assign nk6   = {2'h0, nk};
  assign total = {nk, 2'h0} + 6'h1C;
  assign ready = (cnt >= total);

  // Four schedule words per step, chained through the previous word.
  always_comb begin
    logic [31:0] prev;
    logic [31:0] t;
    logic [5:0]  idx;
    prev = w[cnt - 6'h01];
    t = 32'h0000_0000;
    idx = cnt;
    for (int j = 0; j < 4; j++) begin
      idx = cnt + 6'(j);
      t = prev;
      if (idx % nk6 == 6'h00) begin
        t = sub_word({prev[23:0], prev[31:24]}) ^ {rcon(4'(idx / nk6)), 24'h00_0000};
      end else if (nk6 == 6'h08 && idx % nk6 == 6'h04) begin
        t = sub_word(prev);
      end
      nw[j] = w[idx - nk6] ^ t;
      prev = nw[j];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 6'h00;
    end else if (ce) begin
      if (load) cnt <= nk6;
      else if (step && !ready) cnt <= cnt + 6'h04;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce) begin
      if (load) begin
        for (int k = 0; k < 8; k++) w[k] <= key[255 - 32*k -: 32];
      end else if (step && !ready) begin
        for (int j = 0; j < 4; j++) begin
          if (cnt + 6'(j) < total) w[cnt + 6'(j)] <= nw[j];
        end
      end
    end
  end

  assign rkey = {w[{rk_idx, 2'h0}], w[{rk_idx, 2'h1}], w[{rk_idx, 2'h2}], w[{rk_idx, 2'h3}]};

endmodule // aes_key_sched
`default_nettype wire

/* aes_block_cipher_engine.sv */
`timescale 1ns/1ps
`default_nettype none
module aes_block_cipher_engine (
  input  wire logic                       core_clk,
  input  wire logic                       rst_n,
  input  wire logic                       ce,
  input  wire logic                       ccr_wr,
  input  wire logic [aes_pkg::CCR_W-1:0]  ccr_wdata,
  output logic      [aes_pkg::CCR_W-1:0]  cipher_control_register,
  output logic                            irq,
  output logic                            aes_active,
  input  wire logic                       comm_busy,
  output logic                            comm_active,
  input  wire logic [31:0]                rng_data,
  input  wire logic                       rng_valid,
  output logic      [aes_pkg::MEM_AW-1:0] mem_addr,
  output logic                            mem_rd,
  output logic                            mem_wr,
  output logic      [aes_pkg::MEM_DW-1:0] mem_wdata,
  input  wire logic [aes_pkg::MEM_DW-1:0] mem_rdata
);
  import aes_pkg::*;

  state_t         state;
  logic           opt_decrypt;
  logic [1:0]     opt_key_size;
  logic           opt_jitter;
  logic           opt_irq_en;
  logic           opt_keygen;
  logic           done;
  logic [6:0]     remain;
  logic [3:0]     pre_cnt;
  logic [3:0]     round;
  logic [2:0]     gen_cnt;
  logic [255:0]   key_q;
  logic [255:0]   gen_next;
  logic [127:0]   blk;
  logic [127:0]   rkey;
  logic [127:0]   round_out;
  logic           busy;
  logic           accept;
  logic           finish;
  logic           ks_ready;
  logic [3:0]     nk;
  logic [3:0]     nr;
  logic [3:0]     rk_idx;
  logic [3:0]     start_pre;
  logic [3:0]     start_post;

  assign busy       = (state != ST_IDLE);
  assign aes_active = busy;
  assign accept     = ce && ccr_wr && ccr_wdata[CCR_START] && !busy;
  assign finish     = (state == ST_WAIT && remain == 7'h00) || state == ST_GEN_WR_HI;
  assign start_pre  = ccr_wdata[CCR_JITTER] ? rng_data[3:0] : 4'h0;
  assign start_post = ccr_wdata[CCR_JITTER] ? rng_data[7:4] : 4'h0;
  assign nk         = key_nk(opt_key_size);
  assign nr         = nk + 4'h6;
  assign rk_idx     = opt_decrypt ? nr - round : round;
  assign gen_next   = {key_q[223:0], rng_data};

  // Status in the low bit and done in the top bit; the rest echo the stored options.
  assign cipher_control_register = {done, opt_keygen, opt_irq_en, opt_jitter, opt_key_size, opt_decrypt, busy};
  assign irq = done && opt_irq_en;

  assign mem_rd = ce && (state == ST_RD_KEY_LO || state == ST_RD_KEY_HI || state == ST_RD_DATA);
  assign mem_wr = ce && (state == ST_WRITE || state == ST_GEN_WR_LO || state == ST_GEN_WR_HI);

  aes_key_sched u_key_sched (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .load     (state == ST_CAP_DATA),
    .step     (state == ST_EXPAND),
    .nk       (nk),
    .key      (key_q),
    .rk_idx   (rk_idx),
    .rkey     (rkey),
    .ready    (ks_ready)
  );

  aes_round u_round (
    .state_in  (blk),
    .rkey      (rkey),
    .decrypt   (opt_decrypt),
    .last      (round == nr),
    .state_out (round_out)
  );

  // Options are taken only while idle, so an operation in flight cannot be disturbed.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opt_decrypt  <= CCR_RESET[CCR_DECRYPT];
      opt_key_size <= CCR_RESET[CCR_KS_HI:CCR_KS_LO];
      opt_jitter   <= CCR_RESET[CCR_JITTER];
      opt_irq_en   <= CCR_RESET[CCR_IRQ_EN];
      opt_keygen   <= CCR_RESET[CCR_KEYGEN];
    end else if (ce && ccr_wr && !busy) begin
      opt_decrypt  <= ccr_wdata[CCR_DECRYPT];
      opt_key_size <= ccr_wdata[CCR_KS_HI:CCR_KS_LO];
      opt_jitter   <= ccr_wdata[CCR_JITTER];
      opt_irq_en   <= ccr_wdata[CCR_IRQ_EN];
      opt_keygen   <= ccr_wdata[CCR_KEYGEN];
    end
  end

  // Completion flag stays up until the next start.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      done <= CCR_RESET[CCR_DONE];
    end else if (ce) begin
      if (finish) done <= 1'b1;
      else if (accept) done <= 1'b0;
    end
  end

  // Cipher run length, jitter included, is fixed at start; a key generation run ends at ST_GEN_WR_HI instead.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= 7'h00;
    end else if (ce) begin
      if (accept) begin
        remain <= base_cycles(ccr_wdata[CCR_KS_HI:CCR_KS_LO]) + {3'h0, start_pre}
                  + {3'h0, start_post} - 7'h01;
      end else if (busy && remain != 7'h00) begin
        remain <= remain - 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      pre_cnt <= 4'h0;
      round   <= 4'h0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            pre_cnt <= start_pre;
            round   <= 4'h0;
            if (ccr_wdata[CCR_KEYGEN]) state <= ST_GEN;
            else if (start_pre != 4'h0) state <= ST_PRE;
            else state <= ST_RD_KEY_LO;
          end
        end
        ST_PRE: begin
          pre_cnt <= pre_cnt - 4'h1;
          if (pre_cnt == 4'h1) state <= ST_RD_KEY_LO;
        end
        ST_RD_KEY_LO: state <= ST_RD_KEY_HI;
        ST_RD_KEY_HI: state <= ST_RD_DATA;
        ST_RD_DATA:   state <= ST_CAP_DATA;
        ST_CAP_DATA:  state <= ST_EXPAND;
        ST_EXPAND: begin
          if (ks_ready) begin
            round <= 4'h1;
            state <= ST_ROUND;
          end
        end
        ST_ROUND: begin
          if (round == nr) state <= ST_WRITE;
          else round <= round + 4'h1;
        end
        ST_WRITE: state <= ST_WAIT;
        ST_WAIT: begin
          if (remain == 7'h00) state <= ST_IDLE;
        end
        ST_GEN: begin
          if (rng_valid && gen_cnt == RNG_WORDS_LAST) state <= ST_GEN_WR_LO;
        end
        ST_GEN_WR_LO: state <= ST_GEN_WR_HI;
        ST_GEN_WR_HI: state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Memory side: addresses and write data are registered on the same edge that enters the state raising their strobe, except MEM_KEY_LO, which is loaded at start.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_addr  <= MEM_KEY_LO;
      mem_wdata <= '0;
      key_q     <= '0;
      blk       <= '0;
      gen_cnt   <= 3'h0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (accept) begin
            mem_addr <= MEM_KEY_LO;
            gen_cnt  <= 3'h0;
          end
        end
        ST_RD_KEY_LO: mem_addr <= MEM_KEY_HI;
        ST_RD_KEY_HI: begin
          key_q[255:128] <= mem_rdata;
          mem_addr       <= MEM_DATA_IN;
        end
        ST_RD_DATA:  key_q[127:0] <= mem_rdata;
        ST_CAP_DATA: blk <= mem_rdata;
        ST_EXPAND: begin
          if (ks_ready) blk <= blk ^ rkey;
        end
        ST_ROUND: begin
          blk <= round_out;
          if (round == nr) begin
            mem_addr  <= MEM_DATA_OUT;
            mem_wdata <= round_out;
          end
        end
        ST_GEN: begin
          if (rng_valid) begin
            key_q   <= gen_next;
            gen_cnt <= gen_cnt + 3'h1;
            if (gen_cnt == RNG_WORDS_LAST) mem_wdata <= gen_next[255:128];
          end
        end
        ST_GEN_WR_LO: begin
          mem_addr  <= MEM_KEY_HI;
          mem_wdata <= key_q[127:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) comm_active <= 1'b0;
    else if (ce) comm_active <= comm_busy;
  end

  // Helper counters read only by the checks below.
  logic [6:0] run_len;
  logic [4:0] pre_len;
  logic       wrote;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_len <= 7'h00;
      pre_len <= 5'h00;
      wrote   <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        run_len <= 7'h00;
        pre_len <= 5'h00;
        wrote   <= 1'b0;
      end else begin
        if (busy) run_len <= run_len + 7'h01;
        if (state == ST_PRE) pre_len <= pre_len + 5'h01;
        if (mem_wr && mem_addr == MEM_DATA_OUT) wrote <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  run_128_a: assert property (
    $rose(done) && !opt_jitter && !opt_keygen && opt_key_size == KS_128 |-> run_len == CYC_128)
    else $error("128-bit run length wrong");
  run_192_a: assert property (
    $rose(done) && !opt_jitter && !opt_keygen && opt_key_size == KS_192 |-> run_len == CYC_192)
    else $error("192-bit run length wrong");
  run_256_a: assert property (
    $rose(done) && !opt_jitter && !opt_keygen && opt_key_size == KS_256 |-> run_len == CYC_256)
    else $error("256-bit run length wrong");
  jitter_span_a: assert property (
    $rose(done) && opt_jitter && !opt_keygen |->
      run_len >= base_cycles(opt_key_size) && run_len <= base_cycles(opt_key_size) + JIT_MAX_TOTAL)
    else $error("jittered run length out of range");
  pre_delay_a: assert property (
    $rose(state == ST_RD_KEY_LO) |-> (opt_jitter ? pre_len <= JIT_MAX_PRE : pre_len == 5'h00))
    else $error("start delay out of range");
  start_clears_a: assert property (
    accept |=> busy && !done ##1 busy)
    else $error("start did not launch the engine");
  done_hold_a: assert property (
    done && !accept |=> done)
    else $error("done dropped without a new start");
  irq_gate_a: assert property (
    $rose(done) && opt_irq_en |-> irq ##1 (irq || accept || !done))
    else $error("enabled completion did not raise interrupt");
  irq_mask_a: assert property (
    !opt_irq_en |-> !irq)
    else $error("interrupt raised while disabled");
  opts_frozen_a: assert property (
    ccr_wr && busy |=> $stable(cipher_control_register[CCR_KEYGEN:CCR_DECRYPT]))
    else $error("options changed during an operation");
  result_written_a: assert property (
    $rose(done) && !opt_keygen |-> wrote)
    else $error("operation ended without writing its result");
  keygen_place_a: assert property (
    mem_wr && opt_keygen |-> mem_addr == MEM_KEY_LO || mem_addr == MEM_KEY_HI)
    else $error("generated key written outside the key location");
  comm_view_a: assert property (
    ce && comm_busy |=> comm_active)
    else $error("link activity not reported");

  enc_128_c: cover property ($rose(done) && !opt_decrypt && opt_key_size == KS_128 && !opt_keygen);
  dec_256_c: cover property ($rose(done) && opt_decrypt && opt_key_size == KS_256 && !opt_keygen);
  jitter_c:  cover property ($rose(done) && opt_jitter && !opt_keygen && run_len > CYC_192);
  keygen_c:  cover property ($rose(done) && opt_keygen);

endmodule // aes_block_cipher_engine
`default_nettype wire

/* crypto_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module crypto_mem_model (
  input  wire logic         core_clk,
  input  wire logic         ce,
  input  wire logic [3:0]   mem_addr,
  input  wire logic         mem_rd,
  input  wire logic         mem_wr,
  input  wire logic [127:0] mem_wdata,
  output logic      [127:0] mem_rdata
);
  logic [127:0] mem [16];

  initial mem_rdata = 128'h0;

  // Read data is good from the cycle after a read until the next enabled cycle; each enabled cycle without a read inverts it so that a late capture shows up.
  always @(posedge core_clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
    if (mem_rd) begin
      mem_rdata <= mem[mem_addr];
    end else if (ce) begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // crypto_mem_model
`default_nettype wire

/* aes_block_cipher_engine_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin mismatches++; $display("ERROR %s expected %h seen %h", nm, e, a); end end
module aes_block_cipher_engine_tb;
  import aes_pkg::*;
  logic         core_clk  = 1'b0;
  logic         rst_n     = 1'b0;
  logic         ce        = 1'b1;
  logic         ccr_wr    = 1'b0;
  logic         comm_busy = 1'b0;
  logic         rng_valid = 1'b0;
  logic         holes     = 1'b0;
  logic [7:0]   ccr_wdata = 8'h00;
  logic [31:0]  rng_data  = 32'h0000_0000;
  logic [7:0]   ccr;
  logic         irq, aes_active, comm_active, mem_rd, mem_wr;
  logic [3:0]   mem_addr;
  logic [127:0] mem_wdata, mem_rdata, pt;
  logic [127:0] ct [4];
  logic [255:0] key;
  logic [131:0] w;
  logic [31:0]  r;
  logic [1:0]   ks;
  int           mismatches = 0;
  int           checks     = 0;
  int           seed       = 45414;
  int           cnt        = 0;
  int           rd_cnt     = 0;
  int           prev_busy  = 0;
  int           c, i;
  int           exp_cyc[$], exp_irq[$];
  logic [131:0] exp_wr[$];

  aes_block_cipher_engine dut (.core_clk(core_clk), .rst_n(rst_n), .ce(ce), .ccr_wr(ccr_wr), .ccr_wdata(ccr_wdata),
    .cipher_control_register(ccr), .irq(irq), .aes_active(aes_active), .comm_busy(comm_busy),
    .comm_active(comm_active), .rng_data(rng_data), .rng_valid(rng_valid), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  crypto_mem_model u_mem (.core_clk(core_clk), .ce(ce), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    forever #50 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge core_clk);
      #10;
    end
  endtask

  task automatic wr_ccr(input logic [7:0] v, input logic [31:0] rv);
    ccr_wdata = v;
    rng_data  = rv;
    ccr_wr    = 1'b1;
    tick();
    ccr_wr    = 1'b0;
  endtask

  task automatic wait_idle();
    int k;
    for (k = 0; k < 400 && ccr[0] !== 1'b0; k++) begin
      ce = holes ? (($random(seed) & 3) != 0) : 1'b1;
      tick();
    end
    ce = 1'b1;
    if (k == 400) begin
      mismatches++;
      $display("ERROR wait_idle expected 0 seen %h", ccr[0]);
      stop_test();
    end
  endtask

  task automatic run_cipher(input logic [7:0] v, input logic [127:0] res, input logic [31:0] rv);
    int n;
    n = v[3:2] == 2'h1 ? 70 : v[3:2] == 2'h2 ? 75 : 55;
    if (v[4]) begin
      n = n + rv[3:0] + rv[7:4];
    end
    exp_cyc.push_back(n);
    exp_irq.push_back(v[5]);
    exp_wr.push_back({4'h3, res});
    wr_ccr(v, rv);
    `CHK("start flags", 2'b01, {ccr[7], aes_active})
    wait_idle();
  endtask

  // Results are matched in order of appearance against the notes left by the driver.
  always @(posedge core_clk) begin
    if (!rst_n) begin
      prev_busy = 0;
      cnt = 0;
      rd_cnt = 0;
    end else begin
      if (mem_wr === 1'b1) begin
        w = exp_wr.size() ? exp_wr.pop_front() : 'x;
        `CHK("memory write", w, {mem_addr, mem_wdata})
      end
      if (ce && ccr[0] === 1'b1) begin
        cnt++;
      end
      if (mem_rd === 1'b1) begin
        rd_cnt++;
      end
      if (prev_busy != 0 && ccr[0] === 1'b0) begin
        c = exp_cyc.size() ? exp_cyc.pop_front() : -2;
        i = exp_irq.size() ? exp_irq.pop_front() : 2;
        if (c != -1) `CHK("run length", c, cnt)
        `CHK("done and irq", {1'b1, i[0]}, {ccr[7], irq})
        `CHK("memory reads", c == -1 ? 0 : 3, rd_cnt)
        cnt = 0;
        rd_cnt = 0;
      end
      prev_busy = ccr[0];
    end
  end

  initial begin
    pt = 128'h0011_2233_4455_6677_8899_aabb_ccdd_eeff;
    key = 256'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f_1011_1213_1415_1617_1819_1a1b_1c1d_1e1f;
    ct[0] = 128'h69c4_e0d8_6a7b_0430_d8cd_b780_70b4_c55a;
    ct[1] = 128'hdda9_7ca4_864c_dfe0_6eaf_70a0_ec0d_7191;
    ct[2] = 128'h8ea2_b7ca_5167_45bf_eafc_4990_4b49_6089;
    ct[3] = ct[0];
    u_mem.mem[0] = key[255:128];
    u_mem.mem[1] = key[127:0];
    u_mem.mem[2] = pt;
    tick(3);
    `CHK("reset view", 11'h000, {ccr, irq, aes_active, mem_wr})
    rst_n = 1'b1;
    for (int d = 0; d < 2; d++) begin
      for (int k = 0; k < 4; k++) begin
        u_mem.mem[2] = d ? ct[k] : pt;
        run_cipher({4'h0, 2'(k), 1'(d), 1'b1}, d ? pt : ct[k], 32'h0000_0000);
      end
    end
    $display("test cipher_modes finished");
    u_mem.mem[2] = pt;
    holes = 1'b1;
    for (int j = 0; j < 6; j++) begin
      r = j == 0 ? 32'h0000_00FF : j == 1 ? 32'h0000_0000 : $random(seed);
      ks = 2'(j % 3);
      run_cipher({2'b00, j[0], 1'b1, ks, 2'b01}, ct[ks], r);
    end
    holes = 1'b0;
    $display("test jitter finished");
    exp_cyc.push_back(55);
    exp_irq.push_back(1);
    exp_wr.push_back({4'h3, ct[0]});
    wr_ccr(8'h21, 32'h0000_0000);
    tick(10);
    wr_ccr(8'h1B, 32'h0000_00FF);
    `CHK("busy write refused", 8'h21, ccr)
    wait_idle();
    tick(5);
    `CHK("done held", 9'h1A0, {irq, ccr})
    wr_ccr(8'h5E, 32'h0000_0000);
    `CHK("options view", 9'h0DE, {irq, ccr})
    $display("test control finished");
    comm_busy = 1'b1;
    tick();
    `CHK("link active", 1'b1, comm_active)
    comm_busy = 1'b0;
    `CHK("link active held", 1'b1, comm_active)
    tick();
    `CHK("link idle", 1'b0, comm_active)
    for (int k = 0; k < 8; k++) begin
      key = {key[223:0], 32'($random(seed))};
    end
    exp_cyc.push_back(-1);
    exp_irq.push_back(0);
    exp_wr.push_back({4'h0, key[255:128]});
    exp_wr.push_back({4'h1, key[127:0]});
    wr_ccr(8'h41, 32'h0000_0000);
    for (int k = 0; k < 8; k++) begin
      rng_data = key[255 - 32 * k -: 32];
      rng_valid = 1'b1;
      tick();
      rng_valid = 1'b0;
      rng_data = $random(seed);
      tick();
    end
    wait_idle();
    $display("test keygen finished");
    wr_ccr(8'h01, 32'h0000_0000);
    tick(20);
    rst_n = 1'b0;
    #1;
    `CHK("reset mid run", 11'h000, {ccr, irq, aes_active, mem_wr})
    tick(2);
    rst_n = 1'b1;
    u_mem.mem[0] = 128'h0001_0203_0405_0607_0809_0a0b_0c0d_0e0f;
    u_mem.mem[1] = 128'h1011_1213_1415_1617_1819_1a1b_1c1d_1e1f;
    tick();
    run_cipher(8'h09, ct[2], 32'h0000_0000);
    tick(2);
    `CHK("queues drained", 0, exp_wr.size() + exp_cyc.size())
    $display("test reset finished");
    stop_test();
  end
endmodule // aes_block_cipher_engine_tb
`default_nettype wire
